// File: src/wake_seq_pkg.sv
package wake_seq_pkg;
  // Register byte offsets.
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] VECTOR_OFFSET = 8'h08;
  localparam logic [7:0] PENDING_OFFSET = 8'h0c;
  // Configuration field positions and reset value.
  localparam int CFG_STOP_ENABLE = 0;
  localparam int CFG_OSC_RUN_IN_STOP = 1;
  localparam int CFG_SHORT_RECOVERY_SEL = 2;
  localparam int CFG_MONITOR_ENABLE = 3;
  localparam int CFG_MONITOR_RESET_ENABLE = 4;
  localparam int CFG_WIDTH = 5;
  localparam logic [4:0] CONFIG_RESET = 5'h00;
  // Status field positions.
  localparam int STS_MODE = 0;
  localparam int STS_RECOVERING = 2;
  localparam int STS_EXIT_BY_RESET = 3;
  localparam int STS_SOURCE = 8;
  // Wake source indices, highest priority first.
  localparam int SRC_EXT_IRQ = 0;
  localparam int SRC_BREAK = 1;
  localparam int SRC_CLKGEN = 2;
  localparam int SRC_FIRST_TIMER_OVF = 3;
  localparam int SRC_FIRST_TIMER_CH1 = 4;
  localparam int SRC_FIRST_TIMER_CH0 = 5;
  localparam int SRC_SECOND_TIMER_OVF = 6;
  localparam int SRC_SECOND_TIMER_CH1 = 7;
  localparam int SRC_SECOND_TIMER_CH0 = 8;
  localparam int SRC_SYNC_TX = 9;
  localparam int SRC_SYNC_RX = 10;
  localparam int SRC_ASYNC_TX = 11;
  localparam int SRC_ASYNC_RX = 12;
  localparam int SRC_ASYNC_ERR = 13;
  localparam int SRC_KEYPAD = 14;
  localparam int SRC_ADC = 15;
  localparam int SRC_TIMEBASE = 16;
  localparam int NUM_SRC = 17;
  localparam logic [4:0] SRC_RESET_CODE = 5'h1f;
  // Sources that are allowed to end stop mode.
  localparam logic [16:0] STOP_WAKE_MASK = 17'h14003;
  // Vector addresses.
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_EXT_IRQ = 16'hfffa;
  localparam logic [15:0] VEC_BREAK = 16'hfffc;
  localparam logic [15:0] VEC_CLKGEN = 16'hfff8;
  localparam logic [15:0] VEC_KEYPAD = 16'hffe0;
  localparam logic [15:0] VEC_FIRST_TIMER_OVF = 16'hfff2;
  localparam logic [15:0] VEC_FIRST_TIMER_CH1 = 16'hfff4;
  localparam logic [15:0] VEC_FIRST_TIMER_CH0 = 16'hfff6;
  localparam logic [15:0] VEC_SECOND_TIMER_OVF = 16'hffec;
  localparam logic [15:0] VEC_SECOND_TIMER_CH1 = 16'hffee;
  localparam logic [15:0] VEC_SECOND_TIMER_CH0 = 16'hfff0;
  localparam logic [15:0] VEC_SYNC_TX = 16'hffe8;
  localparam logic [15:0] VEC_SYNC_RX = 16'hffea;
  localparam logic [15:0] VEC_ASYNC_TX = 16'hffe2;
  localparam logic [15:0] VEC_ASYNC_RX = 16'hffe4;
  localparam logic [15:0] VEC_ASYNC_ERR = 16'hffe6;
  localparam logic [15:0] VEC_ADC = 16'hffde;
  localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;
  // Recovery counts in oscillator cycles, and the oscillator divider.
  localparam int RECOVERY_FULL_CYCLES = 4096;
  localparam int RECOVERY_SHORT_CYCLES = 32;
  localparam int RECOVERY_WIDTH = 12;
  localparam int OSC_DIVIDE = 4;
  // Mode codes in the status register.
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_WAIT = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_RECOVER = 2'h3;

  typedef enum logic [1:0] {run_st, wait_st, stop_st, recover_st} mode_type;
endpackage

// File: src/osc_tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module osc_tick_divider #(
  parameter int DIVIDE = wake_seq_pkg::OSC_DIVIDE
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Oscillator control.
  input wire logic run,
  output logic tick
);
  logic [7:0] count;

  // The divider restarts while stopped so the first tick after a restart is a full period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count == 8'(DIVIDE - 1)) begin
      count <= 8'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/stop_recovery_counter.sv
`timescale 1ns/1ps
`default_nettype none
module stop_recovery_counter #(
  parameter int WIDTH = wake_seq_pkg::RECOVERY_WIDTH
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Control.
  input wire logic start,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic tick,
  // Status.
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count <= load_value;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && tick) begin
      if (count == '0) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count - 1'b1;
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/low_power_wake_sequencer.sv
// Overview of operation
// - External interrupt unit stays active; wakes wait or stop only while unmasked.
// - Keypad unit stays active; wakes wait or stop only while its mask is zero.
// - Enabled supply monitor stays active; its enabled reset ends wait or stop.
// - Enabled serial and timer interrupts end wait mode.
// - Async serial unit halts in stop, keeps registers, resumes after exit.
// - Sync serial unit halts in stop; a reset exit aborts and resets it.
// - Timers halt in stop keeping their state, continuing after interrupt exit.
// - Timebase runs in stop only with oscillator-in-stop set; its rollover wakes.
// - Timebase register is blocked from the processor in wait and stop.
// - Reset pin, watchdog timeout or supply drop reset and use vector FFFE.
// - External pin uses vector FFFA; break uses vector FFFC.
// - Clock generator loop uses FFF8; keypad uses FFE0.
// - First timer: overflow FFF2, channel 1 FFF4, channel 0 FFF6.
// - Second timer: overflow FFEC, channel 1 FFEE, channel 0 FFF0.
// - Sync serial: transmitter FFE8, receiver FFEA.
// - Async serial: transmit FFE2, receive FFE4, receive error FFE6.
// - Converter complete uses FFDE; timebase uses FFDC.
// - Only reset, pin, keypad, monitor, break or timebase end stop.
// - After stop exit a 12-bit counter holds clocks off 4096 oscillator cycles.
// - Short recovery select cuts the stop recovery to 32 oscillator cycles.
// - Wait or stop clears the mask; reset exit sets it again.
// - Stop halts oscillator and loop unless oscillator-in-stop is set; then loop only.
// - Stop takes effect only while the stop enable bit is set.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module low_power_wake_sequencer #(
  parameter int FULL_RECOVERY = wake_seq_pkg::RECOVERY_FULL_CYCLES,
  parameter int SHORT_RECOVERY = wake_seq_pkg::RECOVERY_SHORT_CYCLES,
  parameter int OSC_DIV = wake_seq_pkg::OSC_DIVIDE
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Processor core.
  input wire logic wait_exec,
  input wire logic stop_exec,
  output logic cpu_clk_en,
  output logic ext_irq_mask_clear,
  output logic ext_irq_mask_set,
  output logic vector_load,
  output logic [15:0] vector_addr,
  // Reset sources.
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic supply_low,
  output logic reset_req,
  // Interrupt sources.
  input wire logic [16:0] irq_req,
  input wire logic ext_irq_mask,
  input wire logic keypad_irq_mask,
  // Clock generator.
  output logic bus_clk_en,
  output logic osc_en,
  output logic pll_en,
  output logic clkgen_out_en,
  // Peripheral controls.
  output logic supply_monitor_run,
  output logic async_serial_halt,
  output logic sync_serial_halt,
  output logic sync_serial_reset,
  output logic timer_halt,
  output logic timebase_run,
  output logic timebase_access_block
);
  wake_seq_pkg::mode_type mode;
  wake_seq_pkg::mode_type next_mode;
  logic [4:0] config_bits;
  logic [16:0] qualified;
  logic reset_event;
  logic any_wake;
  logic [4:0] wake_src;
  logic [15:0] pending_vector;
  logic [4:0] last_src;
  logic exit_by_reset;
  logic rec_start;
  logic rec_busy;
  logic rec_done;
  logic osc_tick;
  logic [11:0] rec_load;
  logic bus_phase;
  logic bus_write;
  logic [7:0] bus_addr;

  localparam logic [4:0] SRC_NONE_FALLBACK = wake_seq_pkg::SRC_RESET_CODE;

  function automatic logic [15:0] vector_of(input logic [4:0] src);
    case (src)
      5'(wake_seq_pkg::SRC_EXT_IRQ): vector_of = wake_seq_pkg::VEC_EXT_IRQ;
      5'(wake_seq_pkg::SRC_BREAK): vector_of = wake_seq_pkg::VEC_BREAK;
      5'(wake_seq_pkg::SRC_CLKGEN): vector_of = wake_seq_pkg::VEC_CLKGEN;
      5'(wake_seq_pkg::SRC_KEYPAD): vector_of = wake_seq_pkg::VEC_KEYPAD;
      5'(wake_seq_pkg::SRC_FIRST_TIMER_OVF): vector_of = wake_seq_pkg::VEC_FIRST_TIMER_OVF;
      5'(wake_seq_pkg::SRC_FIRST_TIMER_CH1): vector_of = wake_seq_pkg::VEC_FIRST_TIMER_CH1;
      5'(wake_seq_pkg::SRC_FIRST_TIMER_CH0): vector_of = wake_seq_pkg::VEC_FIRST_TIMER_CH0;
      5'(wake_seq_pkg::SRC_SECOND_TIMER_OVF): vector_of = wake_seq_pkg::VEC_SECOND_TIMER_OVF;
      5'(wake_seq_pkg::SRC_SECOND_TIMER_CH1): vector_of = wake_seq_pkg::VEC_SECOND_TIMER_CH1;
      5'(wake_seq_pkg::SRC_SECOND_TIMER_CH0): vector_of = wake_seq_pkg::VEC_SECOND_TIMER_CH0;
      5'(wake_seq_pkg::SRC_SYNC_TX): vector_of = wake_seq_pkg::VEC_SYNC_TX;
      5'(wake_seq_pkg::SRC_SYNC_RX): vector_of = wake_seq_pkg::VEC_SYNC_RX;
      5'(wake_seq_pkg::SRC_ASYNC_TX): vector_of = wake_seq_pkg::VEC_ASYNC_TX;
      5'(wake_seq_pkg::SRC_ASYNC_RX): vector_of = wake_seq_pkg::VEC_ASYNC_RX;
      5'(wake_seq_pkg::SRC_ASYNC_ERR): vector_of = wake_seq_pkg::VEC_ASYNC_ERR;
      5'(wake_seq_pkg::SRC_ADC): vector_of = wake_seq_pkg::VEC_ADC;
      5'(wake_seq_pkg::SRC_TIMEBASE): vector_of = wake_seq_pkg::VEC_TIMEBASE;
      default: vector_of = wake_seq_pkg::VEC_RESET;
    endcase
  endfunction

  function automatic logic [1:0] mode_code(input wake_seq_pkg::mode_type m);
    case (m)
      wake_seq_pkg::wait_st: mode_code = wake_seq_pkg::MODE_WAIT;
      wake_seq_pkg::stop_st: mode_code = wake_seq_pkg::MODE_STOP;
      wake_seq_pkg::recover_st: mode_code = wake_seq_pkg::MODE_RECOVER;
      default: mode_code = wake_seq_pkg::MODE_RUN;
    endcase
  endfunction

  // Resets come from the pin, the watchdog and an enabled supply monitor with its reset enabled.
  always_comb begin
    reset_event = !ext_reset_n || watchdog_timeout;
    if (config_bits[wake_seq_pkg::CFG_MONITOR_ENABLE] &&
        config_bits[wake_seq_pkg::CFG_MONITOR_RESET_ENABLE] && supply_low) begin
      reset_event = 1'b1;
    end
  end

  // Peripherals only raise requests that they have enabled, so wait takes them all except a masked pin or keypad request.
  always_comb begin
    qualified = irq_req;
    if (ext_irq_mask) begin
      qualified[wake_seq_pkg::SRC_EXT_IRQ] = 1'b0;
    end
    if (keypad_irq_mask) begin
      qualified[wake_seq_pkg::SRC_KEYPAD] = 1'b0;
    end
    if (mode != wake_seq_pkg::wait_st) begin
      qualified = qualified & wake_seq_pkg::STOP_WAKE_MASK;
      if (!config_bits[wake_seq_pkg::CFG_OSC_RUN_IN_STOP]) begin
        qualified[wake_seq_pkg::SRC_TIMEBASE] = 1'b0;
      end
    end
  end

  // Lowest index wins among interrupts.
  always_comb begin
    wake_src = SRC_NONE_FALLBACK;
    for (int i = wake_seq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (qualified[i]) begin
        wake_src = 5'(i);
      end
    end
    any_wake = |qualified;
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      wake_seq_pkg::run_st: begin
        if (reset_event) begin
          next_mode = wake_seq_pkg::run_st;
        end else if (wait_exec) begin
          next_mode = wake_seq_pkg::wait_st;
        end else if (stop_exec && config_bits[wake_seq_pkg::CFG_STOP_ENABLE]) begin
          next_mode = wake_seq_pkg::stop_st;
        end
      end
      wake_seq_pkg::wait_st: begin
        if (reset_event || any_wake) begin
          next_mode = wake_seq_pkg::run_st;
        end
      end
      wake_seq_pkg::stop_st: begin
        if (reset_event || any_wake) begin
          next_mode = wake_seq_pkg::recover_st;
        end
      end
      default: begin
        if (rec_done && !reset_event) begin
          next_mode = wake_seq_pkg::run_st;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= wake_seq_pkg::run_st;
    end else begin
      mode <= next_mode;
    end
  end

  // A reset during recovery restarts the count and turns the exit into a reset exit.
  assign rec_start = (mode == wake_seq_pkg::stop_st && next_mode == wake_seq_pkg::recover_st) ||
                     (mode == wake_seq_pkg::recover_st && reset_event);
  assign rec_load = config_bits[wake_seq_pkg::CFG_SHORT_RECOVERY_SEL] ?
                    12'(SHORT_RECOVERY - 1) : 12'(FULL_RECOVERY - 1);

  osc_tick_divider #(
    .DIVIDE(OSC_DIV)
  ) u_divider (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(osc_en),
    .tick(osc_tick)
  );

  stop_recovery_counter #(
    .WIDTH(wake_seq_pkg::RECOVERY_WIDTH)
  ) u_recovery (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(rec_start),
    .load_value(rec_load),
    .tick(osc_tick),
    .busy(rec_busy),
    .done(rec_done)
  );

  // Wake cause is captured when the mode is left and replayed when clocks restart.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_vector <= wake_seq_pkg::VEC_RESET;
      last_src <= wake_seq_pkg::SRC_RESET_CODE;
      exit_by_reset <= 1'b0;
    end else if (reset_event && mode != wake_seq_pkg::stop_st) begin
      pending_vector <= wake_seq_pkg::VEC_RESET;
      last_src <= wake_seq_pkg::SRC_RESET_CODE;
      exit_by_reset <= 1'b1;
    end else if (mode == wake_seq_pkg::stop_st && reset_event) begin
      pending_vector <= wake_seq_pkg::VEC_RESET;
      last_src <= wake_seq_pkg::SRC_RESET_CODE;
      exit_by_reset <= 1'b1;
    end else if ((mode == wake_seq_pkg::wait_st || mode == wake_seq_pkg::stop_st) &&
                 any_wake) begin
      pending_vector <= vector_of(wake_src);
      last_src <= wake_src;
      exit_by_reset <= 1'b0;
    end
  end

  // Registered requests toward the core, high one cycle after each cycle that their cause holds.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_load <= 1'b0;
      vector_addr <= wake_seq_pkg::VEC_RESET;
      ext_irq_mask_clear <= 1'b0;
      ext_irq_mask_set <= 1'b0;
      reset_req <= 1'b0;
      sync_serial_reset <= 1'b0;
    end else begin
      vector_load <= 1'b0;
      ext_irq_mask_clear <= 1'b0;
      ext_irq_mask_set <= 1'b0;
      reset_req <= reset_event;
      sync_serial_reset <= reset_event && (mode == wake_seq_pkg::stop_st ||
                                           mode == wake_seq_pkg::recover_st);
      if (mode == wake_seq_pkg::run_st && next_mode != wake_seq_pkg::run_st) begin
        ext_irq_mask_clear <= 1'b1;
      end
      if (reset_event && mode != wake_seq_pkg::stop_st && mode != wake_seq_pkg::recover_st) begin
        vector_load <= 1'b1;
        vector_addr <= wake_seq_pkg::VEC_RESET;
        ext_irq_mask_set <= 1'b1;
      end else if (mode == wake_seq_pkg::wait_st && any_wake) begin
        vector_load <= 1'b1;
        vector_addr <= vector_of(wake_src);
      end else if (mode == wake_seq_pkg::recover_st && next_mode == wake_seq_pkg::run_st) begin
        vector_load <= 1'b1;
        vector_addr <= pending_vector;
        ext_irq_mask_set <= exit_by_reset;
      end
    end
  end

  // Clock and peripheral gating follow the mode directly.
  always_comb begin
    cpu_clk_en = (mode == wake_seq_pkg::run_st);
    bus_clk_en = 1'b1;
    osc_en = 1'b1;
    pll_en = 1'b1;
    clkgen_out_en = 1'b1;
    if (mode == wake_seq_pkg::stop_st) begin
      pll_en = 1'b0;
      if (!config_bits[wake_seq_pkg::CFG_OSC_RUN_IN_STOP]) begin
        osc_en = 1'b0;
        clkgen_out_en = 1'b0;
        bus_clk_en = 1'b0;
      end
    end
    if (mode == wake_seq_pkg::recover_st) begin
      bus_clk_en = 1'b0;
      clkgen_out_en = 1'b0;
    end
    supply_monitor_run = config_bits[wake_seq_pkg::CFG_MONITOR_ENABLE];
    async_serial_halt = (mode == wake_seq_pkg::stop_st ||
                         mode == wake_seq_pkg::recover_st);
    sync_serial_halt = async_serial_halt;
    timer_halt = async_serial_halt;
    timebase_run = !async_serial_halt || config_bits[wake_seq_pkg::CFG_OSC_RUN_IN_STOP];
    timebase_access_block = (mode != wake_seq_pkg::run_st);
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_phase <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 8'h00;
    end else if (hready) begin
      bus_phase <= hsel && htrans[1];
      bus_write <= hwrite;
      bus_addr <= haddr[7:0];
    end
  end

  // Software must leave short recovery cleared for crystal systems; reset keeps it clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_bits <= wake_seq_pkg::CONFIG_RESET;
    end else if (bus_phase && bus_write && bus_addr == wake_seq_pkg::CONFIG_OFFSET) begin
      config_bits <= hwdata[4:0];
    end
  end

  // Read data is sampled at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == wake_seq_pkg::CONFIG_OFFSET) begin
        hrdata <= {27'h0000000, config_bits};
      end else if (haddr[7:0] == wake_seq_pkg::STATUS_OFFSET) begin
        hrdata <= {19'h00000, last_src, 4'h0, exit_by_reset, rec_busy, mode_code(mode)};
      end else if (haddr[7:0] == wake_seq_pkg::VECTOR_OFFSET) begin
        hrdata <= {16'h0000, pending_vector};
      end else if (haddr[7:0] == wake_seq_pkg::PENDING_OFFSET) begin
        hrdata <= {15'h0000, qualified};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Mask requests from the sequencer.
  input wire logic ext_irq_mask_clear,
  input wire logic ext_irq_mask_set,
  // Interrupt mask of the core, high while interrupts are blocked.
  output logic mask
);
  // Set wins over clear, so a reset exit always leaves interrupts blocked.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= 1'b1;
    end else if (ext_irq_mask_set) begin
      mask <= 1'b1;
    end else if (ext_irq_mask_clear) begin
      mask <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: test/wake_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wake_seq_asserts #(
  parameter int FULL_RECOVERY = wake_seq_pkg::RECOVERY_FULL_CYCLES,
  parameter int SHORT_RECOVERY = wake_seq_pkg::RECOVERY_SHORT_CYCLES,
  parameter int OSC_DIV = wake_seq_pkg::OSC_DIVIDE
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Core and sources.
  input wire logic wait_exec,
  input wire logic ext_reset_n,
  input wire logic watchdog_timeout,
  input wire logic supply_low,
  input wire logic [16:0] irq_req,
  input wire logic ext_irq_mask,
  input wire logic keypad_irq_mask,
  // Outputs watched.
  input wire logic cpu_clk_en,
  input wire logic ext_irq_mask_clear,
  input wire logic ext_irq_mask_set,
  input wire logic vector_load,
  input wire logic [15:0] vector_addr,
  input wire logic reset_req,
  input wire logic bus_clk_en,
  input wire logic osc_en,
  input wire logic pll_en,
  input wire logic clkgen_out_en,
  input wire logic async_serial_halt,
  input wire logic sync_serial_halt,
  input wire logic timer_halt,
  input wire logic timebase_run,
  input wire logic timebase_access_block
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Wait is the only gated state that keeps the loop and its outputs alive.
  wire logic in_wait = !cpu_clk_en && pll_en && clkgen_out_en;
  wire logic no_reset = ext_reset_n && !watchdog_timeout && !supply_low;
  a_reset_passed: assert property ((!ext_reset_n || watchdog_timeout) |=> reset_req)
    else $error("reset event not passed on");
  a_reset_exit_vec: assert property (ext_irq_mask_set |-> vector_load && vector_addr == 16'hfffe)
    else $error("reset exit without reset vector");
  a_wait_clears_mask: assert property (cpu_clk_en && wait_exec && no_reset
    |=> ext_irq_mask_clear)
    else $error("wait did not clear mask");
  a_masked_pin_idle: assert property (in_wait && no_reset && ext_irq_mask
    && keypad_irq_mask && irq_req == 17'h04001 |=> !vector_load)
    else $error("masked source woke the part");
  a_wait_timer_wake: assert property (in_wait && no_reset && irq_req == 17'h8
    |=> vector_load && vector_addr == 16'hfff2 && cpu_clk_en)
    else $error("timer did not end wait");
  a_osc_off_quiet: assert property (!cpu_clk_en && !osc_en
    |-> !clkgen_out_en && !timebase_run && !bus_clk_en)
    else $error("clocks alive with oscillator off");
  a_gated_no_access: assert property (!cpu_clk_en |-> timebase_access_block)
    else $error("timebase open while gated");
  a_run_all_live: assert property (cpu_clk_en
    |-> bus_clk_en && !timer_halt && !async_serial_halt && !sync_serial_halt)
    else $error("unit halted in run");
  a_stop_halts: assert property (!cpu_clk_en && !pll_en
    |-> timer_halt && async_serial_halt && sync_serial_halt)
    else $error("unit running in stop");
  c_wait_wake: cover property (in_wait ##1 vector_load);
  c_stop_entry: cover property (!cpu_clk_en && !pll_en);
  c_reset_exit: cover property (ext_irq_mask_set);
endmodule
bind low_power_wake_sequencer wake_seq_asserts #(.FULL_RECOVERY(FULL_RECOVERY),
  .SHORT_RECOVERY(SHORT_RECOVERY), .OSC_DIV(OSC_DIV)) wake_seq_asserts_i (.*);
`default_nettype wire

// File: test/low_power_wake_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module low_power_wake_sequencer_tb;
  localparam int FULL = 8;
  localparam int SHORT = 2;
  localparam int DIV = 2;
  localparam logic [15:0] vec [17] = '{16'hfffa, 16'hfffc, 16'hfff8, 16'hfff2, 16'hfff4,
    16'hfff6, 16'hffec, 16'hffee, 16'hfff0, 16'hffe8, 16'hffea, 16'hffe2, 16'hffe4,
    16'hffe6, 16'hffe0, 16'hffde, 16'hffdc};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wait_exec = 1'b0;
  logic stop_exec = 1'b0, ext_reset_n = 1'b1, watchdog_timeout = 1'b0, supply_low = 1'b0;
  logic ext_irq_mask = 1'b0, keypad_irq_mask = 1'b0, sync_rst_seen = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [16:0] irq_req = 17'h0;
  logic [15:0] vector_addr;
  logic hreadyout, hresp, cpu_clk_en, ext_irq_mask_clear, ext_irq_mask_set, vector_load, reset_req;
  logic bus_clk_en, osc_en, pll_en, clkgen_out_en, supply_monitor_run, async_serial_halt;
  logic sync_serial_halt, sync_serial_reset, timer_halt, timebase_run, timebase_access_block;
  logic core_mask;
  int num_errors = 0, total_checks = 0, cycles = 0;
  low_power_wake_sequencer #(.FULL_RECOVERY(FULL), .SHORT_RECOVERY(SHORT), .OSC_DIV(DIV))
    low_power_wake_sequencer_i (.hsize(3'h2), .hready(hreadyout), .*);
  core_model core_model_i (.mask(core_mask), .*);
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (sync_serial_reset === 1'b1) sync_rst_seen <= 1'b1;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic enter(input logic stop);
    wait_exec <= ~stop;
    stop_exec <= stop;
    @(posedge hclk);
    wait_exec <= 1'b0;
    stop_exec <= 1'b0;
    repeat (3) @(negedge hclk);
    @(posedge hclk);
  endtask
  // Counts negative edges from the request until the vector is loaded.
  task automatic wake(input logic [16:0] req, output int n);
    irq_req <= req;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (vector_load !== 1'b1 && n < 2000);
    @(posedge hclk);
    irq_req <= 17'h0;
  endtask
  task automatic t_registers();
    logic [31:0] rd;
    bus(1'b1, 8'h10, 32'hffffffff, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0, "config reset");
    bus(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h0000fffe, "vector reset");
    $display("t_registers done");
  endtask
  task automatic t_wait();
    int n;
    for (int i = 0; i < 17; i++) begin
      enter(1'b0);
      chk(32'({cpu_clk_en, bus_clk_en, core_mask}), 32'h2, "wait entry");
      wake(17'h1 << i, n);
      chk(32'(n == 2), 32'h1, "wait wake delay");
      chk(32'(vector_addr), 32'(vec[i]), "vector");
    end
    $display("t_wait done");
  endtask
  task automatic t_masks();
    int n;
    ext_irq_mask <= 1'b1;
    keypad_irq_mask <= 1'b1;
    enter(1'b0);
    irq_req <= 17'h04001;
    repeat (8) @(posedge hclk);
    chk(32'(cpu_clk_en), 32'h0, "masked wake");
    keypad_irq_mask <= 1'b0;
    wake(17'h04009, n);
    chk(32'(vector_addr), 32'h0000fff2, "priority");
    enter(1'b0);
    wake(17'h04001, n);
    chk(32'(vector_addr), 32'h0000ffe0, "keypad wake");
    ext_irq_mask <= 1'b0;
    $display("t_masks done");
  endtask
  task automatic t_stop_off();
    enter(1'b1);
    chk(32'(cpu_clk_en), 32'h1, "stop disabled");
    $display("t_stop_off done");
  endtask
  task automatic t_stop(input logic [4:0] cfg, input int src, input int len);
    logic [31:0] rd;
    int n;
    bus(1'b1, 8'h00, 32'(cfg), rd);
    enter(1'b1);
    chk(32'({pll_en, osc_en, bus_clk_en, timebase_run}), 32'({3{cfg[1]}}), "clocks");
    chk(32'(timer_halt & async_serial_halt & sync_serial_halt), 32'h1, "halt");
    irq_req <= 17'h00008;
    repeat (8) @(posedge hclk);
    chk(32'(cpu_clk_en), 32'h0, "timer ended stop");
    wake(17'h1 << src, n);
    chk(32'(n >= len && n <= len + 8), 32'h1, "recovery length");
    chk(32'(vector_addr), 32'(vec[src]), "stop vector");
    chk(32'(core_mask), 32'h0, "mask kept");
    $display("t_stop done");
  endtask
  task automatic t_resets();
    logic [31:0] rd;
    int n;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, 32'h19, rd);
      enter(1'b0);
      chk(32'(supply_monitor_run), 32'h1, "monitor in wait");
      ext_reset_n <= (i != 0);
      watchdog_timeout <= (i == 1);
      supply_low <= (i == 2);
      wake(17'h8, n);
      ext_reset_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      supply_low <= 1'b0;
      chk(32'(vector_addr), 32'h0000fffe, "reset vector");
      @(negedge hclk);
      chk(32'(core_mask), 32'h1, "mask set");
      @(posedge hclk);
    end
    bus(1'b1, 8'h00, 32'h19, rd);
    enter(1'b1);
    chk(32'(sync_rst_seen), 32'h0, "sync unit quiet");
    ext_reset_n <= 1'b0;
    repeat (2) @(posedge hclk);
    ext_reset_n <= 1'b1;
    wake(17'h0, n);
    chk(32'(n >= FULL * DIV && n <= FULL * DIV + 8), 32'h1, "reset recovery");
    chk(32'(sync_rst_seen), 32'h1, "sync unit reset");
    chk(32'(vector_addr), 32'h0000fffe, "stop reset vector");
    $display("t_resets done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_registers();
    t_wait();
    t_masks();
    t_stop_off();
    // The first and last runs keep the full recovery count; the middle one selects the short count.
    t_stop(5'h01, 0, FULL * DIV);
    t_stop(5'h05, 14, SHORT * DIV);
    t_stop(5'h03, 16, FULL * DIV);
    t_resets();
    summarize();
  end
endmodule
`default_nettype wire
